// ===== logic/cls_pkg.sv
// types shared by the limit switch control
package cls_pkg;
  typedef enum logic [2:0] {
    CLS_PS_OFF = 3'b000,
    CLS_PS_STARTUP = 3'b001,
    CLS_PS_PRE_ACTIVE = 3'b010,
    CLS_PS_ACTIVE = 3'b011,
    CLS_PS_SLEEP = 3'b100,
    CLS_PS_SHUTDOWN = 3'b101
  } cls_pwr_state_t;
  typedef enum logic [1:0] {
    CLS_OC_IGNORE = 2'b00,
    CLS_OC_OPEN = 2'b01,
    CLS_OC_SHUT_A = 2'b10,
    CLS_OC_SHUT_B = 2'b11
  } cls_oc_resp_t;
  typedef enum logic [1:0] {
    CLS_FLT_IDLE = 2'b00,
    CLS_FLT_COUNT = 2'b01,
    CLS_FLT_QUAL = 2'b10
  } cls_flt_state_t;
endpackage

// ===== logic/cls_regs.svh
// register offsets, field positions, slot codes and timing counts for the limit switch control
`ifndef CLS_REGS_SVH
`define CLS_REGS_SVH
`define CLS_ADDR_REQ_EN 8'h0D
`define CLS_ADDR_OC_STATUS 8'h1D
`define CLS_ADDR_OC_MASK 8'h25
`define CLS_ADDR_REQ_EN_ALIAS 8'hB0
`define CLS_ADDR_CONTROL 8'hC7
`define CLS_ADDR_FAULT_CFG 8'hD7
`define CLS_ADDR_SW_STATUS 8'hE0
`define CLS_BIT_ENA_REQ 15
`define CLS_BIT_OC_FLAG 15
`define CLS_BIT_OC_MASK 15
`define CLS_BIT_FAULT_EXCL 15
`define CLS_FLD_RESP_HI 15
`define CLS_FLD_RESP_LO 14
`define CLS_FLD_START_HI 13
`define CLS_FLD_START_LO 10
`define CLS_FLD_SHUT_HI 9
`define CLS_FLD_SHUT_LO 6
`define CLS_BIT_SLEEP_BEH 4
`define CLS_BIT_BULK_SLEEP 1
`define CLS_BIT_BULK_ACTIVE 0
`define CLS_SLOT_NEVER 4'h0
`define CLS_SLOT_ON_ACTIVE 4'hF
`define CLS_OC_FILTER_NS 1000
`define CLS_CLK_PERIOD_NS 40
`define CLS_OC_FILTER_CYC ((`CLS_OC_FILTER_NS + `CLS_CLK_PERIOD_NS - 1) / `CLS_CLK_PERIOD_NS)
`endif

// ===== logic/cls_switch_ctrl.sv
// limit switch control: enable, slots, sleep, bulk detect, over-current and fault output
`include "cls_regs.svh"

module cls_switch_ctrl #(
  parameter int OC_FILTER_CYC = `CLS_OC_FILTER_CYC,
  parameter logic [3:0] CUSTOM_START_SLOT = 4'h1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire cls_pkg::cls_pwr_state_t pwr_state_in,
  input wire logic seq_slot_strobe_in,
  input wire logic [3:0] seq_slot_in,
  input wire logic custom_mode_in,
  input wire logic oc_raw_in,
  input wire logic other_fault_n_in,
  output logic switch_close_out,
  output logic bulk_detect_en_out,
  output logic overcurrent_group_irq_out,
  output logic system_shutdown_out,
  output logic supply_fault_n_out
);
  logic [2:0] oc_sync_q;
  logic switch_enable_request_q;
  logic [3:0] startup_slot_select_q;
  logic [3:0] shutdown_slot_select_q;
  logic switch_sleep_behaviour_q;
  logic bulk_detect_active_open_q;
  logic bulk_detect_sleep_open_q;
  logic [1:0] overcurrent_response_q;
  logic switch_overcurrent_irq_mask_q;
  logic switch_fault_exclude_q;
  logic switch_overcurrent_flag_q;
  logic sw_on_q;
  logic oc_trip_q;
  logic oc_filt_q;
  logic oc_filt_prev_q;
  logic [15:0] oc_cnt_q;
  logic shutdown_q;
  logic [15:0] rdata_q;
  logic req_sel;
  logic wr_req;
  logic wr_ctrl;
  logic rd_status;
  logic oc_edge;
  logic startup_hit;
  logic shutdown_hit;
  logic entering_active;
  cls_pkg::cls_pwr_state_t prev_state_q;
  cls_pkg::cls_flt_state_t flt_state_q;
  cls_pkg::cls_oc_resp_t resp;

  // decode; both request addresses land on the same bit
  always_comb begin
    req_sel = 1'b0;
    if (addr_in == `CLS_ADDR_REQ_EN) begin
      req_sel = 1'b1;
    end else if (addr_in == `CLS_ADDR_REQ_EN_ALIAS) begin
      req_sel = 1'b1;
    end
  end
  assign wr_req = wr_in && req_sel;
  assign wr_ctrl = wr_in && (addr_in == `CLS_ADDR_CONTROL);
  assign rd_status = rd_in && (addr_in == `CLS_ADDR_OC_STATUS);
  assign resp = cls_pkg::cls_oc_resp_t'(overcurrent_response_q);

  // sequencer slot events
  assign entering_active = (pwr_state_in == cls_pkg::CLS_PS_ACTIVE) &&
                           (prev_state_q != cls_pkg::CLS_PS_ACTIVE) &&
                           (prev_state_q != cls_pkg::CLS_PS_SLEEP);
  assign startup_hit = (pwr_state_in == cls_pkg::CLS_PS_STARTUP) && seq_slot_strobe_in &&
                       (startup_slot_select_q != `CLS_SLOT_NEVER) &&
                       (startup_slot_select_q != `CLS_SLOT_ON_ACTIVE) &&
                       (seq_slot_in == startup_slot_select_q);
  assign shutdown_hit = (pwr_state_in == cls_pkg::CLS_PS_SHUTDOWN) && seq_slot_strobe_in &&
                        (shutdown_slot_select_q != `CLS_SLOT_NEVER) &&
                        (shutdown_slot_select_q != `CLS_SLOT_ON_ACTIVE) &&
                        (seq_slot_in == shutdown_slot_select_q);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prev_state_q <= cls_pkg::CLS_PS_OFF;
    end else begin
      prev_state_q <= pwr_state_in;
    end
  end

  // enable request; hardware setting wins over a software clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      switch_enable_request_q <= 1'b0;
    end else if (startup_hit) begin
      switch_enable_request_q <= 1'b1;
    end else if (entering_active && startup_slot_select_q == `CLS_SLOT_ON_ACTIVE) begin
      switch_enable_request_q <= 1'b1;
    end else if (wr_req) begin
      switch_enable_request_q <= wdata_in[`CLS_BIT_ENA_REQ];
    end
  end

  // control register; custom modes force the start-up slot preset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      startup_slot_select_q <= 4'h0;
      shutdown_slot_select_q <= 4'h0;
      switch_sleep_behaviour_q <= 1'b0;
      bulk_detect_active_open_q <= 1'b1;
      bulk_detect_sleep_open_q <= 1'b1;
      overcurrent_response_q <= 2'h0;
    end else begin
      if (custom_mode_in) begin
        startup_slot_select_q <= CUSTOM_START_SLOT;
      end else if (wr_ctrl) begin
        startup_slot_select_q <= wdata_in[`CLS_FLD_START_HI:`CLS_FLD_START_LO];
      end
      if (wr_ctrl) begin
        shutdown_slot_select_q <= wdata_in[`CLS_FLD_SHUT_HI:`CLS_FLD_SHUT_LO];
        switch_sleep_behaviour_q <= wdata_in[`CLS_BIT_SLEEP_BEH];
        bulk_detect_active_open_q <= wdata_in[`CLS_BIT_BULK_ACTIVE];
        bulk_detect_sleep_open_q <= wdata_in[`CLS_BIT_BULK_SLEEP];
        overcurrent_response_q <= wdata_in[`CLS_FLD_RESP_HI:`CLS_FLD_RESP_LO];
      end
    end
  end

  // mask and fault-output configuration
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      switch_overcurrent_irq_mask_q <= 1'b0;
      switch_fault_exclude_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == `CLS_ADDR_OC_MASK) begin
        switch_overcurrent_irq_mask_q <= wdata_in[`CLS_BIT_OC_MASK];
      end
      if (wr_in && addr_in == `CLS_ADDR_FAULT_CFG) begin
        switch_fault_exclude_q <= wdata_in[`CLS_BIT_FAULT_EXCL];
      end
    end
  end

  // raw over-current comes from the analog side: three-stage sync, agree on last two
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oc_sync_q <= 3'h0;
    end else begin
      oc_sync_q <= {oc_sync_q[1:0], oc_raw_in};
    end
  end

  // persistence filter, so short surges never flag a fault
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flt_state_q <= cls_pkg::CLS_FLT_IDLE;
      oc_cnt_q <= 16'h0000;
    end else if (oc_sync_q[2] == oc_sync_q[1]) begin
      case (flt_state_q)
        cls_pkg::CLS_FLT_IDLE: begin
          oc_cnt_q <= 16'h0000;
          if (oc_sync_q[2]) begin
            flt_state_q <= cls_pkg::CLS_FLT_COUNT;
          end
        end
        cls_pkg::CLS_FLT_COUNT: begin
          if (!oc_sync_q[2]) begin
            flt_state_q <= cls_pkg::CLS_FLT_IDLE;
          end else if (oc_cnt_q >= 16'(OC_FILTER_CYC - 1)) begin
            flt_state_q <= cls_pkg::CLS_FLT_QUAL;
          end else begin
            oc_cnt_q <= oc_cnt_q + 16'h0001;
          end
        end
        cls_pkg::CLS_FLT_QUAL: begin
          if (!oc_sync_q[2]) begin
            flt_state_q <= cls_pkg::CLS_FLT_IDLE;
          end
        end
        default: begin
          flt_state_q <= cls_pkg::CLS_FLT_IDLE;
        end
      endcase
    end
  end

  assign oc_filt_q = (flt_state_q == cls_pkg::CLS_FLT_QUAL);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oc_filt_prev_q <= 1'b0;
    end else begin
      oc_filt_prev_q <= oc_filt_q;
    end
  end
  assign oc_edge = oc_filt_q && !oc_filt_prev_q;

  // sticky flag: a new edge in the reading cycle survives the clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      switch_overcurrent_flag_q <= 1'b0;
    end else if (oc_edge) begin
      switch_overcurrent_flag_q <= 1'b1;
    end else if (rd_status) begin
      switch_overcurrent_flag_q <= 1'b0;
    end
  end

  // over-current response; trip holds the switch open until request is rewritten or the power state is off
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oc_trip_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      if (oc_edge && resp == cls_pkg::CLS_OC_OPEN) begin
        oc_trip_q <= 1'b1;
      end else if (wr_req || pwr_state_in == cls_pkg::CLS_PS_OFF) begin
        oc_trip_q <= 1'b0;
      end
      if (oc_edge && (resp == cls_pkg::CLS_OC_SHUT_A || resp == cls_pkg::CLS_OC_SHUT_B)) begin
        shutdown_q <= 1'b1;
      end else if (pwr_state_in == cls_pkg::CLS_PS_OFF) begin
        shutdown_q <= 1'b0;
      end
    end
  end

  // actual switch state, by power state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sw_on_q <= 1'b0;
    end else if (oc_trip_q || (oc_edge && resp == cls_pkg::CLS_OC_OPEN)) begin
      sw_on_q <= 1'b0;
    end else begin
      case (pwr_state_in)
        cls_pkg::CLS_PS_ACTIVE: sw_on_q <= switch_enable_request_q;
        cls_pkg::CLS_PS_STARTUP: if (startup_hit) sw_on_q <= 1'b1;
        cls_pkg::CLS_PS_SLEEP: if (!switch_sleep_behaviour_q) sw_on_q <= 1'b0;
        cls_pkg::CLS_PS_SHUTDOWN: if (shutdown_hit) sw_on_q <= 1'b0;
        cls_pkg::CLS_PS_OFF: sw_on_q <= 1'b0;
        default: sw_on_q <= sw_on_q; // pre-active holds; request waits
      endcase
    end
  end

  assign switch_close_out = sw_on_q;
  assign system_shutdown_out = shutdown_q;

  // bulk detection: forced on while closed, else per state bit
  always_comb begin
    if (sw_on_q) begin
      bulk_detect_en_out = 1'b1;
    end else if (pwr_state_in == cls_pkg::CLS_PS_SLEEP) begin
      bulk_detect_en_out = bulk_detect_sleep_open_q;
    end else begin
      bulk_detect_en_out = bulk_detect_active_open_q;
    end
  end

  assign overcurrent_group_irq_out = switch_overcurrent_flag_q &&
                                     !switch_overcurrent_irq_mask_q;
  // fault output follows the live qualified condition, not the sticky flag
  assign supply_fault_n_out = other_fault_n_in &&
                              !(oc_filt_q && !switch_fault_exclude_q);

  // read data; unmapped addresses read zero, read data valid one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_q <= 16'h0000;
    end else if (rd_in) begin
      if (req_sel) begin
        rdata_q <= {switch_enable_request_q, 15'h0000};
      end else if (addr_in == `CLS_ADDR_OC_STATUS) begin
        rdata_q <= {switch_overcurrent_flag_q, 15'h0000};
      end else if (addr_in == `CLS_ADDR_OC_MASK) begin
        rdata_q <= {switch_overcurrent_irq_mask_q, 15'h0000};
      end else if (addr_in == `CLS_ADDR_CONTROL) begin
        rdata_q <= {overcurrent_response_q, startup_slot_select_q, shutdown_slot_select_q,
                    1'b0, switch_sleep_behaviour_q, 2'h0, bulk_detect_sleep_open_q,
                    bulk_detect_active_open_q};
      end else if (addr_in == `CLS_ADDR_FAULT_CFG) begin
        rdata_q <= {switch_fault_exclude_q, 15'h0000};
      end else if (addr_in == `CLS_ADDR_SW_STATUS) begin
        rdata_q <= {sw_on_q, oc_filt_q, oc_trip_q, 13'h0000};
      end else begin
        rdata_q <= 16'h0000;
      end
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign rdata_out = rdata_q;

  // checks
  sequence s_qual_edge;
    oc_filt_q && !oc_filt_prev_q;
  endsequence
  chk_flag_on_edge: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_qual_edge |=> switch_overcurrent_flag_q)
    else $error("flag not set after qualified edge");
  chk_read_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rd_status && !oc_edge |=> !switch_overcurrent_flag_q)
    else $error("flag not cleared by read");
  chk_mask_blocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    switch_overcurrent_irq_mask_q |-> !overcurrent_group_irq_out)
    else $error("masked flag raised interrupt");
  chk_bulk_when_closed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sw_on_q |-> bulk_detect_en_out)
    else $error("bulk detect off while closed");
  chk_active_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pwr_state_in == cls_pkg::CLS_PS_ACTIVE && !oc_trip_q && !oc_edge
    |=> sw_on_q == $past(switch_enable_request_q))
    else $error("switch not following request");
  chk_preactive_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pwr_state_in == cls_pkg::CLS_PS_PRE_ACTIVE && !sw_on_q |=> !sw_on_q)
    else $error("switch closed in pre-active");
  chk_sleep_opens: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pwr_state_in == cls_pkg::CLS_PS_SLEEP && !switch_sleep_behaviour_q |=> !sw_on_q)
    else $error("switch closed in sleep");
  chk_off_opens: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pwr_state_in == cls_pkg::CLS_PS_OFF |=> !sw_on_q)
    else $error("switch closed in off");
  chk_no_short_fault: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !oc_sync_q[2] ##1 s_qual_edge |-> 1'b0)
    else $error("fault qualified without persistence");
  chk_fault_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    oc_filt_q && !switch_fault_exclude_q |-> !supply_fault_n_out)
    else $error("fault output not low");

  // helper: cycles since the synchronised line last agreed low; saturates, never wraps
  logic [15:0] oc_run_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      oc_run_q <= 16'h0000;
    end else if (!oc_sync_q[2] && !oc_sync_q[1]) begin
      oc_run_q <= 16'h0000;
    end else if (oc_run_q != 16'hFFFF) begin
      oc_run_q <= oc_run_q + 16'h0001;
    end
  end
  sequence s_trip_open;
    oc_edge && resp == cls_pkg::CLS_OC_OPEN;
  endsequence
  sequence s_trip_shut;
    oc_edge && overcurrent_response_q[1];
  endsequence
  chk_filter_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_qual_edge |-> oc_run_q > 16'(OC_FILTER_CYC))
    else $error("fault qualified before filter count");
  chk_open_response: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_trip_open |=> !switch_close_out)
    else $error("switch not opened on over-current");
  chk_shut_response: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_trip_shut |=> system_shutdown_out)
    else $error("shutdown not raised on over-current");
  chk_start_slot_close: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    startup_hit && !oc_trip_q && !oc_edge |=> switch_close_out && switch_enable_request_q)
    else $error("start-up slot did not close switch");
  chk_custom_preset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    custom_mode_in |=> startup_slot_select_q == CUSTOM_START_SLOT)
    else $error("custom mode preset not loaded");
endmodule

// ===== testbench/cls_switch_ctrl_bench.sv
// self-checking bench for the limit switch control, driven through its register port
`include "cls_regs.svh"
module cls_switch_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // short filter keeps the over-current waits brief; waits below assume 3 sync + 3 filter cycles
  localparam int FILT = 3;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  cls_pkg::cls_pwr_state_t pwr_state_in = cls_pkg::CLS_PS_OFF;
  logic seq_slot_strobe_in = 1'b0;
  logic [3:0] seq_slot_in = 4'h0;
  logic custom_mode_in = 1'b0;
  logic oc_raw_in = 1'b0;
  logic other_fault_n_in = 1'b1;
  logic switch_close_out;
  logic bulk_detect_en_out;
  logic overcurrent_group_irq_out;
  logic system_shutdown_out;
  logic supply_fault_n_out;
  logic [15:0] obs;
  int bad_count = 0;
  int total_checks = 0;

  // output bundle: 10 closed, 08 bulk detect, 04 irq, 02 shutdown, 01 fault_n
  assign obs = {11'h000, switch_close_out, bulk_detect_en_out, overcurrent_group_irq_out,
                system_shutdown_out, supply_fault_n_out};

  cls_switch_ctrl #(.OC_FILTER_CYC(FILT), .CUSTOM_START_SLOT(4'h7)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwr_state_in(pwr_state_in),
    .seq_slot_strobe_in(seq_slot_strobe_in), .seq_slot_in(seq_slot_in),
    .custom_mode_in(custom_mode_in), .oc_raw_in(oc_raw_in),
    .other_fault_n_in(other_fault_n_in), .switch_close_out(switch_close_out),
    .bulk_detect_en_out(bulk_detect_en_out),
    .overcurrent_group_irq_out(overcurrent_group_irq_out),
    .system_shutdown_out(system_shutdown_out), .supply_fault_n_out(supply_fault_n_out));

  // 25 MHz system clock
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // sample one ns past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  task automatic go(input cls_pkg::cls_pwr_state_t s);
    @(posedge sys_clk_in);
    pwr_state_in <= s;
    tick(3);
  endtask

  task automatic slot(input logic [3:0] n);
    @(posedge sys_clk_in);
    seq_slot_strobe_in <= 1'b1;
    seq_slot_in <= n;
    @(posedge sys_clk_in);
    seq_slot_strobe_in <= 1'b0;
    tick(1);
  endtask

  // level change on the raw over-current line, then enough time to qualify or settle
  task automatic set_oc(input logic v);
    @(posedge sys_clk_in);
    oc_raw_in <= v;
    tick(12);
  endtask

  // sweep start-up and shutdown slots 1..14 with one pair of slot fields
  task automatic run_slots(input logic [3:0] st, input logic [3:0] sd);
    logic on;
    go(cls_pkg::CLS_PS_OFF);
    wr(`CLS_ADDR_REQ_EN, 16'h0000);
    wr(`CLS_ADDR_CONTROL, {2'b00, st, sd, 6'h03});
    go(cls_pkg::CLS_PS_STARTUP);
    for (int i = 1; i <= 14; i++) begin
      slot(4'(i));
      on = (st != 4'h0) && (st != 4'hF) && (i >= st);
      chk(obs, {11'h000, on, 4'h9});
    end
    go(cls_pkg::CLS_PS_ACTIVE);
    on = (st != 4'h0);
    chk(obs, {11'h000, on, 4'h9});
    rd(`CLS_ADDR_REQ_EN, {on, 15'h0000});
    go(cls_pkg::CLS_PS_SHUTDOWN);
    for (int i = 1; i <= 14; i++) begin
      slot(4'(i));
      chk(obs, {11'h000, on && (sd == 4'h0 || sd == 4'hF || i < sd), 4'h9});
    end
    go(cls_pkg::CLS_PS_OFF);
    chk(obs, 16'h0009);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the tests need about a thousand cycles, so 20000 means a hang
  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    tick(1);
    chk(obs, 16'h0009);
    rd(`CLS_ADDR_CONTROL, 16'h0003);
    rd(`CLS_ADDR_REQ_EN, 16'h0000);
    wr(8'h55, 16'hFFFF);
    rd(8'h55, 16'h0000);
    $display("test reset done");
    // a request made in pre-active must wait for active; alias shares the bit
    go(cls_pkg::CLS_PS_PRE_ACTIVE);
    wr(`CLS_ADDR_REQ_EN_ALIAS, 16'h8000);
    tick(3);
    chk(obs, 16'h0009);
    rd(`CLS_ADDR_REQ_EN, 16'h8000);
    go(cls_pkg::CLS_PS_ACTIVE);
    chk(obs, 16'h0019);
    rd(`CLS_ADDR_SW_STATUS, 16'h8000);
    wr(`CLS_ADDR_REQ_EN, 16'h0000);
    tick(3);
    chk(obs, 16'h0019 & 16'h0009);
    rd(`CLS_ADDR_REQ_EN_ALIAS, 16'h0000);
    $display("test enable done");
    // open switch: bulk detect follows the bit of the current state
    wr(`CLS_ADDR_CONTROL, 16'h0002);
    tick(1);
    chk(obs, 16'h0001);
    go(cls_pkg::CLS_PS_SLEEP);
    chk(obs, 16'h0009);
    wr(`CLS_ADDR_CONTROL, 16'h0001);
    tick(1);
    chk(obs, 16'h0001);
    go(cls_pkg::CLS_PS_ACTIVE);
    chk(obs, 16'h0009);
    wr(`CLS_ADDR_CONTROL, 16'h0000);
    wr(`CLS_ADDR_REQ_EN, 16'h8000);
    tick(3);
    chk(obs, 16'h0019);
    go(cls_pkg::CLS_PS_SLEEP);
    chk(obs, 16'h0001);
    wr(`CLS_ADDR_CONTROL, 16'h0010);
    go(cls_pkg::CLS_PS_ACTIVE);
    go(cls_pkg::CLS_PS_SLEEP);
    chk(obs, 16'h0019);
    $display("test bulk and sleep done");
    run_slots(4'h5, 4'h3);
    run_slots(4'h0, 4'h0);
    run_slots(4'hF, 4'hF);
    run_slots(4'h1, 4'hE);
    run_slots(4'hE, 4'h1);
    $display("test slots done");
    // custom mode replaces software's start-up slot with the preset
    @(posedge sys_clk_in);
    custom_mode_in <= 1'b1;
    wr(`CLS_ADDR_CONTROL, 16'h1403);
    rd(`CLS_ADDR_CONTROL, 16'h1C03);
    @(posedge sys_clk_in);
    custom_mode_in <= 1'b0;
    $display("test custom mode done");
    go(cls_pkg::CLS_PS_ACTIVE);
    wr(`CLS_ADDR_CONTROL, 16'h0003);
    wr(`CLS_ADDR_REQ_EN, 16'h8000);
    // a surge shorter than the filter raises nothing
    @(posedge sys_clk_in);
    oc_raw_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    oc_raw_in <= 1'b0;
    tick(12);
    chk(obs, 16'h0019);
    rd(`CLS_ADDR_OC_STATUS, 16'h0000);
    set_oc(1'b1);
    chk(obs, 16'h001C);
    rd(`CLS_ADDR_SW_STATUS, 16'hC000);
    set_oc(1'b0);
    chk(obs, 16'h001D);
    wr(`CLS_ADDR_OC_STATUS, 16'h0000);
    rd(`CLS_ADDR_OC_STATUS, 16'h8000);
    rd(`CLS_ADDR_OC_STATUS, 16'h0000);
    tick(1);
    chk(obs, 16'h0019);
    // masked flag still latches but raises no irq; excluded switch leaves fault high
    wr(`CLS_ADDR_OC_MASK, 16'h8000);
    wr(`CLS_ADDR_FAULT_CFG, 16'h8000);
    rd(`CLS_ADDR_OC_MASK, 16'h8000);
    rd(`CLS_ADDR_FAULT_CFG, 16'h8000);
    set_oc(1'b1);
    chk(obs, 16'h0019);
    @(posedge sys_clk_in);
    other_fault_n_in <= 1'b0;
    tick(1);
    chk(obs, 16'h0018);
    @(posedge sys_clk_in);
    other_fault_n_in <= 1'b1;
    set_oc(1'b0);
    rd(`CLS_ADDR_OC_STATUS, 16'h8000);
    wr(`CLS_ADDR_OC_MASK, 16'h0000);
    wr(`CLS_ADDR_FAULT_CFG, 16'h0000);
    $display("test mask done");
    // response 01 opens the switch until software asks again
    wr(`CLS_ADDR_CONTROL, 16'h4003);
    set_oc(1'b1);
    chk(obs, 16'h000C);
    set_oc(1'b0);
    chk(obs, 16'h000D);
    rd(`CLS_ADDR_OC_STATUS, 16'h8000);
    wr(`CLS_ADDR_REQ_EN, 16'h8000);
    tick(3);
    chk(obs, 16'h0019);
    // both shutdown codes stop the system until off
    for (int r = 2; r <= 3; r++) begin
      wr(`CLS_ADDR_CONTROL, {2'(r), 14'h0003});
      set_oc(1'b1);
      chk(obs & 16'h0002, 16'h0002);
      set_oc(1'b0);
      chk(obs & 16'h0002, 16'h0002);
      go(cls_pkg::CLS_PS_OFF);
      chk(obs & 16'h0002, 16'h0000);
      rd(`CLS_ADDR_OC_STATUS, 16'h8000);
      go(cls_pkg::CLS_PS_ACTIVE);
      wr(`CLS_ADDR_REQ_EN, 16'h8000);
      tick(3);
    end
    $display("test over-current response done");
    tally_and_finish();
  end
endmodule
